// ---- design/ctm_map.svh ----
// Function
// - Three modes: compare-match output, timer/event counter, PWM output.
// - One external clock input, two output pins, same or inverse signal.
// - Ten-bit up-counter advanced by the selected clock source.
// - Period comparator checks three-bit value against counter bits 9 to 7.
// - Match-A comparator checks ten-bit value against all counter bits.
// - Software cannot load the counter; only timer-on rising edge clears it.
// - Counter clears on overflow or compare match, raising event flags.
// - Counter readable as low byte bits 7-0, high byte bits 9-8.
// - Match value held in read/write byte pair, reset zero.
// - High counter and high match bytes read zero in bits 7 to 2.
// - Pause bit freezes counter; clearing resumes from held value.
// - Clock select: sys/4, sys, high/16, high/64, timebase, pin edges.
// - Reserved clock-select code 101 gives no counter clock.
// - Timer-on enables counting, clear stops and holds, rise zeroes.
// - Compare mode: timer-on rise restores output to initial level bit.
// - Low bytes go through one 8-bit buffer, moved on high-byte access.
// - Period codes 1 to 7 match at 128 times code; 0 overflows.
// - Clear-select: 0 period match or overflow, 1 match-A; unused in PWM.
// - Mode field: 00 compare, 10 PWM, 11 timer, 01 undefined.
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH

`define CTM_OFF_CTRL0 3'h0
`define CTM_OFF_CTRL1 3'h1
`define CTM_OFF_CNT_LO 3'h2
`define CTM_OFF_CNT_HI 3'h3
`define CTM_OFF_MATCH_LO 3'h4
`define CTM_OFF_MATCH_HI 3'h5
`define CTM_OFF_FLAGS 3'h6
`define CTM_OFF_OUTCFG 3'h7

`define CTM_C0_PAUSE 7
`define CTM_C0_CKSEL_HI 6
`define CTM_C0_CKSEL_LO 4
`define CTM_C0_ON 3
`define CTM_C0_PER_HI 2
`define CTM_C0_PER_LO 0
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_IO_HI 5
`define CTM_C1_IO_LO 4
`define CTM_C1_INIT 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CCLR 0
`define CTM_FLAG_A 0
`define CTM_FLAG_P 1
`define CTM_OCFG_B_INV 0

`define CTM_RST_BYTE 8'h00
`define CTM_RST_CNT 10'h000
`define CTM_CNT_MAX 10'h3FF
`define CTM_PER_NONE 3'h0
`define CTM_SYS_DIV_LAST 2'h3
`define CTM_HDIV16_LAST 6'h0F
`define CTM_HDIV64_LAST 6'h3F
`define CTM_IO_NONE 2'h0
`define CTM_IO_LOW 2'h1
`define CTM_IO_HIGH 2'h2
`define CTM_IO_TOGGLE 2'h3

`endif

// ---- design/ctm_pkg.sv ----
package ctm_pkg;
  typedef enum logic [2:0] {
    CTM_CK_SYS4 = 3'h0,
    CTM_CK_SYS = 3'h1,
    CTM_CK_H16 = 3'h2,
    CTM_CK_H64 = 3'h3,
    CTM_CK_TBC = 3'h4,
    CTM_CK_RSVD = 3'h5,
    CTM_CK_EXT_RISE = 3'h6,
    CTM_CK_EXT_FALL = 3'h7
  } ctm_cksel_t;

  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'h0,
    CTM_MODE_UNDEF = 2'h1,
    CTM_MODE_PWM = 2'h2,
    CTM_MODE_TMR = 2'h3
  } ctm_mode_t;
endpackage : ctm_pkg

// ---- design/ctm_top.sv ----
`timescale 1ns/1ns
`include "ctm_map.svh"

module ctm_top
  import ctm_pkg::*;
(
  input wire logic clk_i, // System clock, 20 MHz
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [2:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  input wire logic hclk_tick_i, // High clock tick, same domain
  input wire logic tbc_clk_i, // Timebase clock level, async
  input wire logic ext_clk_i, // External clock pin, async
  output logic tp_a_o, // Timer output pin a
  output logic tp_b_o, // Timer output pin b
  output logic flag_a_o, // Match-A event flag
  output logic flag_p_o // Period event flag
);

  ////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  logic [1:0] rst_sync_q;
  logic rst_b;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  // Reset to the idle-low pin level, so no false edge follows reset
  logic [2:0] ext_sync_q;
  logic [2:0] tbc_sync_q;
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync_q <= 3'h0;
      tbc_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_clk_i};
      tbc_sync_q <= {tbc_sync_q[1:0], tbc_clk_i};
    end
  end

  logic ext_rise;
  logic ext_fall;
  logic tbc_rise;
  assign ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
  assign ext_fall = ~ext_sync_q[1] & ext_sync_q[2];
  assign tbc_rise = tbc_sync_q[1] & ~tbc_sync_q[2];

  ////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [9:0] match_q;
  logic [7:0] buf_q;
  logic [7:0] rdata_q;
  logic out_b_inv_q;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic flag_a_q;
  logic flag_p_q;

  logic wr_c0;
  logic wr_c1;
  logic wr_ocfg;
  logic wr_mlo;
  logic wr_mhi;
  logic rd_chi;
  logic rd_mhi;
  logic timer_on;
  logic pause;
  logic [2:0] per_code;
  logic [1:0] io_sel;
  logic init_lvl;
  logic pol;
  logic dpx;
  logic cclr;
  ctm_cksel_t cksel;
  ctm_mode_t mode;

  assign wr_c0 = wr_i && addr_i == `CTM_OFF_CTRL0;
  assign wr_c1 = wr_i && addr_i == `CTM_OFF_CTRL1;
  assign timer_on = ctrl0_q[`CTM_C0_ON];
  assign pause = ctrl0_q[`CTM_C0_PAUSE];
  assign per_code = ctrl0_q[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
  assign cksel = ctm_cksel_t'(ctrl0_q[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO]);
  assign mode = ctm_mode_t'(ctrl1_q[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);
  assign io_sel = ctrl1_q[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
  assign init_lvl = ctrl1_q[`CTM_C1_INIT];
  assign pol = ctrl1_q[`CTM_C1_POL];
  assign dpx = ctrl1_q[`CTM_C1_DPX];
  assign cclr = ctrl1_q[`CTM_C1_CCLR];
  assign wr_ocfg = wr_i && addr_i == `CTM_OFF_OUTCFG;
  assign wr_mlo = wr_i && addr_i == `CTM_OFF_MATCH_LO;
  assign wr_mhi = wr_i && addr_i == `CTM_OFF_MATCH_HI;
  assign rd_chi = rd_i && addr_i == `CTM_OFF_CNT_HI;
  assign rd_mhi = rd_i && addr_i == `CTM_OFF_MATCH_HI;

  // Control writes land whole; nothing is locked while running
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_q <= `CTM_RST_BYTE;
    end else if (wr_c0) begin
      ctrl0_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_q <= `CTM_RST_BYTE;
    end else if (wr_c1) begin
      ctrl1_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      out_b_inv_q <= 1'b0;
    end else if (wr_ocfg) begin
      out_b_inv_q <= wdata_i[`CTM_OCFG_B_INV];
    end
  end

  // Low-byte buffer and match pair
  // One buffer for both pairs: a high read spoils a pending low write
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      buf_q <= `CTM_RST_BYTE;
      match_q <= `CTM_RST_CNT;
    end else begin
      if (wr_mlo) begin
        buf_q <= wdata_i;
      end else if (wr_mhi) begin
        match_q <= {wdata_i[1:0], buf_q};
      end else if (rd_chi) begin
        buf_q <= cnt_q[7:0];
      end else if (rd_mhi) begin
        buf_q <= match_q[7:0];
      end
    end
  end

  // Read data, one cycle after the strobe
  // Idle value zero keeps the bus quiet between reads
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= `CTM_RST_BYTE;
    end else if (rd_i) begin
      unique case (addr_i)
        `CTM_OFF_CTRL0: rdata_q <= ctrl0_q;
        `CTM_OFF_CTRL1: rdata_q <= ctrl1_q;
        `CTM_OFF_CNT_LO: rdata_q <= buf_q;
        `CTM_OFF_CNT_HI: rdata_q <= {6'h00, cnt_q[9:8]};
        `CTM_OFF_MATCH_LO: rdata_q <= buf_q;
        `CTM_OFF_MATCH_HI: rdata_q <= {6'h00, match_q[9:8]};
        `CTM_OFF_FLAGS: rdata_q <= {6'h00, flag_p_q, flag_a_q};
        `CTM_OFF_OUTCFG: rdata_q <= {7'h00, out_b_inv_q};
      endcase
    end else begin
      rdata_q <= `CTM_RST_BYTE;
    end
  end
  assign rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////
  // Clock source selection
  logic [1:0] sys_div_q;
  logic [5:0] h_div_q;
  logic tick;
  logic h16_last;
  logic h64_last;

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      sys_div_q <= 2'h0;
      h_div_q <= 6'h00;
    end else begin
      sys_div_q <= sys_div_q + 2'h1;
      if (hclk_tick_i) begin
        h_div_q <= h_div_q + 6'h01;
      end
    end
  end

  // Dividers run free, so a new selection may start mid-period
  assign h16_last = h_div_q[3:0] == 4'(`CTM_HDIV16_LAST);
  assign h64_last = h_div_q == `CTM_HDIV64_LAST;

  always_comb begin
    unique case (cksel)
      CTM_CK_SYS4: tick = sys_div_q == `CTM_SYS_DIV_LAST;
      CTM_CK_SYS: tick = 1'b1;
      CTM_CK_H16: tick = hclk_tick_i && h16_last;
      CTM_CK_H64: tick = hclk_tick_i && h64_last;
      CTM_CK_TBC: tick = tbc_rise;
      CTM_CK_RSVD: tick = 1'b0;
      CTM_CK_EXT_RISE: tick = ext_rise;
      CTM_CK_EXT_FALL: tick = ext_fall;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Counter and comparators
  logic on_prev_q;
  logic on_rise;
  logic step;
  logic [9:0] cnt_inc;
  logic hit_p;
  logic hit_a;
  logic ovf;
  logic clr;
  logic ev_a;
  logic ev_p;

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= timer_on;
    end
  end
  assign on_rise = timer_on & ~on_prev_q;

  // Off and pause both hold the count; only on-rise zeroes it
  assign step = tick && timer_on && !pause;
  assign cnt_inc = cnt_q + 10'h001;
  // 3FF wraps to zero by itself; no clear needed
  assign ovf = cnt_q == `CTM_CNT_MAX;
  // Period code scales by 128 through the top three bits
  assign hit_p = per_code != `CTM_PER_NONE &&
                 cnt_inc[9:7] == per_code &&
                 cnt_inc[6:0] == 7'h00;
  // Match value zero never hits, so the count overflows quietly
  assign hit_a = match_q != `CTM_RST_CNT && cnt_inc == match_q;

  always_comb begin
    clr = 1'b0;
    ev_a = 1'b0;
    ev_p = 1'b0;
    if (step) begin
      if (mode == CTM_MODE_PWM) begin
        // Period source picked by the duty/period swap bit
        clr = dpx ? hit_a : (hit_p || (per_code == `CTM_PER_NONE && ovf));
        ev_a = hit_a;
        ev_p = hit_p || (per_code == `CTM_PER_NONE && ovf);
      end else if (cclr) begin
        clr = hit_a;
        ev_a = hit_a;
      end else begin
        clr = hit_p;
        ev_a = hit_a;
        ev_p = hit_p || (per_code == `CTM_PER_NONE && ovf);
      end
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (on_rise) begin
      cnt_d = `CTM_RST_CNT;
    end else if (step) begin
      cnt_d = clr ? `CTM_RST_CNT : cnt_inc;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= `CTM_RST_CNT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Sticky flags, write one to clear; a new event wins
  logic wr_flags;
  assign wr_flags = wr_i && addr_i == `CTM_OFF_FLAGS;
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      flag_a_q <= 1'b0;
    end else if (ev_a) begin
      flag_a_q <= 1'b1;
    end else if (wr_flags && wdata_i[`CTM_FLAG_A]) begin
      flag_a_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      flag_p_q <= 1'b0;
    end else if (ev_p) begin
      flag_p_q <= 1'b1;
    end else if (wr_flags && wdata_i[`CTM_FLAG_P]) begin
      flag_p_q <= 1'b0;
    end
  end
  assign flag_a_o = flag_a_q;
  assign flag_p_o = flag_p_q;

  ////////////////////////////////////////////////////////////////
  // Output generation
  logic cmp_lvl_q;
  logic pwm_act;
  logic lvl;
  logic pin_a;
  logic tp_a_q;
  logic tp_b_q;

  // Level moves on A events and reloads the initial level on on-rise; period events leave it alone
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cmp_lvl_q <= 1'b0;
    end else if (mode == CTM_MODE_CMP) begin
      if (on_rise) begin
        cmp_lvl_q <= init_lvl;
      end else if (ev_a) begin
        unique case (io_sel)
          `CTM_IO_NONE: cmp_lvl_q <= cmp_lvl_q;
          `CTM_IO_LOW: cmp_lvl_q <= 1'b0;
          `CTM_IO_HIGH: cmp_lvl_q <= 1'b1;
          `CTM_IO_TOGGLE: cmp_lvl_q <= ~cmp_lvl_q;
        endcase
      end
    end
  end

  // PWM active while counter is below the duty value
  always_comb begin
    if (dpx) begin
      pwm_act = cnt_q[9:7] < per_code;
    end else begin
      pwm_act = cnt_q < match_q;
    end
  end

  always_comb begin
    unique case (mode)
      CTM_MODE_CMP: lvl = cmp_lvl_q;
      CTM_MODE_PWM: begin
        unique case (io_sel)
          2'h0: lvl = ~init_lvl;
          2'h1: lvl = init_lvl;
          2'h2: lvl = pwm_act ? init_lvl : ~init_lvl;
          default: lvl = 1'b0;
        endcase
      end
      default: lvl = 1'b0;
    endcase
  end

  // Timer/counter and undefined modes hold pin a low; pin b follows its inverse setting
  assign pin_a = (mode == CTM_MODE_PWM || mode == CTM_MODE_CMP) ?
                 (lvl ^ pol) : 1'b0;

  // Pin b carries pin a or its inverse
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      tp_a_q <= 1'b0;
      tp_b_q <= 1'b0;
    end else begin
      tp_a_q <= pin_a;
      tp_b_q <= pin_a ^ out_b_inv_q;
    end
  end
  assign tp_a_o = tp_a_q;
  assign tp_b_o = tp_b_q;

endmodule : ctm_top

// ---- sim/ctm_top_monitor.sv ----
`timescale 1ns/1ns
module ctm_top_monitor (
  input wire logic clk_i, // Clock
  input wire logic rst_b_i, // Reset
  input wire logic [2:0] addr_i, // Address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write
  input wire logic rd_i, // Read
  input wire logic [7:0] rdata_o, // Read data
  input wire logic tp_a_o, // Pin a
  input wire logic tp_b_o, // Pin b
  input wire logic flag_a_o, // Flag a
  input wire logic flag_p_o // Flag p
);
  logic [7:0] c0_q;
  logic inv_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) c0_q <= 8'h00;
    else if (wr_i && addr_i == 3'h0) c0_q <= wdata_i;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) inv_q <= 1'b0;
    else if (wr_i && addr_i == 3'h7) inv_q <= wdata_i[0];
  end
  //////////////////////////////
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  cnt_hi_a: assert property ($past(rd_i && addr_i == 3'h3) |->
    rdata_o[7:2] == 6'h00) else $error("counter high top bits set");
  mat_hi_a: assert property ($past(rd_i && addr_i == 3'h5) |->
    rdata_o[7:2] == 6'h00) else $error("match high top bits set");
  ctl_read_a: assert property ($past(rd_i && addr_i == 3'h0) |->
    rdata_o == $past(c0_q)) else $error("control 0 readback wrong");
  fa_clear_a: assert property ($fell(flag_a_o) |->
    $past(wr_i && addr_i == 3'h6 && wdata_i[0])) else $error("flag a lost");
  fp_clear_a: assert property ($fell(flag_p_o) |->
    $past(wr_i && addr_i == 3'h6 && wdata_i[1])) else $error("flag p lost");
  pin_b_a: assert property (inv_q == $past(inv_q) &&
    inv_q == $past(inv_q, 2) |-> tp_b_o == (tp_a_o ^ inv_q))
    else $error("pin b not tied to pin a");
  off_still_a: assert property ($rose(flag_p_o) |-> $past(c0_q[3]) ||
    $past(c0_q[3], 2) || $past(c0_q[3], 3)) else $error("event while off");
  cover property (rd_i && addr_i == 3'h3);
  cover property ($rose(flag_p_o));
  cover property ($rose(flag_a_o));
endmodule : ctm_top_monitor

bind ctm_top ctm_top_monitor i_mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .tp_a_o(tp_a_o), .tp_b_o(tp_b_o),
  .flag_a_o(flag_a_o), .flag_p_o(flag_p_o));

// ---- sim/tb_ctm_top.sv ----
`timescale 1ns/1ns
module tb_ctm_top;
  logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic hclk_tick_i = 1'b0, tbc_clk_i = 1'b0, ext_clk_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o, v;
  logic tp_a_o, tp_b_o, flag_a_o, flag_p_o;
  int mismatches = 0, samples_checked = 0, k;
  // Row: op, addr or source, data or count, expected
  logic [23:0] rows [] = '{
    24'h0_0_00_00, 24'h0_1_00_00, 24'h0_3_00_00, 24'h0_2_00_00,
    24'h0_5_00_00, 24'h0_4_00_00, 24'h0_6_00_00, 24'h0_7_00_00,
    24'h1_4_34_00, 24'h1_5_FD_00, 24'h0_5_00_01, 24'h0_4_00_34,
    24'h1_2_AA_00, 24'h1_3_FF_00, 24'h3_0_00_00,
    24'h1_1_C5_00, 24'h0_1_00_C5, 24'h1_1_00_00,
    24'h1_0_68_00, 24'h0_0_00_68, 24'h2_0_05_00, 24'h3_0_00_05,
    24'h1_0_78_00, 24'h2_0_03_00, 24'h3_0_00_08, 24'h1_0_48_00,
    24'h2_1_04_00, 24'h3_0_00_0C, 24'h1_0_28_00, 24'h2_2_20_00,
    24'h3_0_00_0E, 24'h1_0_38_00, 24'h2_2_40_00, 24'h3_0_00_0F,
    24'h1_0_58_00, 24'h2_0_03_00, 24'h3_0_00_0F,
    24'h1_0_E8_00, 24'h2_0_03_00, 24'h3_0_00_0F, 24'h1_0_68_00,
    24'h2_0_02_00, 24'h3_0_00_11, 24'h1_0_60_00, 24'h2_0_02_00,
    24'h3_0_00_11, 24'h1_0_68_00, 24'h3_0_00_00, 24'h1_0_00_00};
  always #25 clk_i = ~clk_i;
  ctm_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .hclk_tick_i(hclk_tick_i), .tbc_clk_i(tbc_clk_i),
    .ext_clk_i(ext_clk_i), .tp_a_o(tp_a_o), .tp_b_o(tp_b_o),
    .flag_a_o(flag_a_o), .flag_p_o(flag_p_o));
  //////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk16
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask : rd
  task automatic pulse(input logic [1:0] s, input logic [7:0] n);
    int w;
    w = (s == 2'h2) ? 1 : 4;
    repeat (n) begin
      if (s == 2'h0) ext_clk_i <= 1'b1;
      else if (s == 2'h1) tbc_clk_i <= 1'b1;
      else hclk_tick_i <= 1'b1;
      cyc(w);
      ext_clk_i <= 1'b0;
      tbc_clk_i <= 1'b0;
      hclk_tick_i <= 1'b0;
      cyc(w);
    end
    cyc(8);
  endtask : pulse
  // Cycles between two events of one flag, clearing it in between
  task automatic gap(input logic p, output int n);
    n = 0;
    while ((p ? flag_p_o : flag_a_o) !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      #1 n++;
    end
    wr(3'h6, p ? 8'h02 : 8'h01);
    n = 2;
    while ((p ? flag_p_o : flag_a_o) !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      #1 n++;
    end
  endtask : gap
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    #1000000;
    mismatches++;
    conclude();
  end
  initial begin
    cyc(2);
    rst_b_i <= 1'b1;
    cyc(3);
    foreach (rows[i]) begin
      case (rows[i][23:20])
        4'h0: begin
          rd(rows[i][18:16], v);
          chk8(v, rows[i][7:0]);
        end
        4'h1: wr(rows[i][18:16], rows[i][15:8]);
        4'h2: pulse(rows[i][17:16], rows[i][15:8]);
        default: begin
          rd(3'h3, v);
          chk8(v, 8'h00);
          rd(3'h2, v);
          chk8(v, rows[i][7:0]);
        end
      endcase
    end
    $display("table done");
    wr(3'h0, 8'h19);
    gap(1'b1, k);
    chk16(k[15:0], 16'h0080);
    chk1(flag_a_o, 1'b0);
    wr(3'h0, 8'h10);
    wr(3'h6, 8'h03);
    chk1(flag_p_o, 1'b0);
    wr(3'h4, 8'h0A);
    wr(3'h5, 8'h00);
    wr(3'h1, 8'h01);
    wr(3'h0, 8'h19);
    gap(1'b0, k);
    chk16(k[15:0], 16'h000A);
    chk1(flag_p_o, 1'b0);
    $display("event timing done");
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h08);
    wr(3'h0, 8'h18);
    cyc(3);
    chk1(tp_a_o, 1'b1);
    chk1(tp_b_o, 1'b1);
    wr(3'h7, 8'h01);
    cyc(2);
    chk1(tp_b_o, 1'b0);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h10);
    wr(3'h0, 8'h18);
    cyc(3);
    chk1(tp_a_o, 1'b0);
    $display("output pins done");
    wr(3'h6, 8'h03);
    gap(1'b1, k);
    chk16(k[15:0], 16'h0400);
    wr(3'h0, 8'h10);
    wr(3'h6, 8'h03);
    wr(3'h0, 8'h09);
    gap(1'b1, k);
    chk16(k[15:0], 16'h0200);
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h21);
    wr(3'h0, 8'h18);
    cyc(2);
    chk1(tp_a_o, 1'b0);
    cyc(12);
    chk1(tp_a_o, 1'b1);
    wr(3'h1, 8'h25);
    cyc(2);
    chk1(tp_a_o, 1'b0);
    chk1(tp_b_o, 1'b1);
    wr(3'h1, 8'h21);
    cyc(2);
    chk1(tp_a_o, 1'b1);
    wr(3'h1, 8'hE1);
    cyc(2);
    chk1(tp_a_o, 1'b0);
    wr(3'h0, 8'h10);
    wr(3'h1, 8'hA8);
    wr(3'h0, 8'h19);
    cyc(4);
    chk1(tp_a_o, 1'b1);
    cyc(16);
    chk1(tp_a_o, 1'b0);
    $display("modes done");
    rst_b_i <= 1'b0;
    cyc(2);
    rst_b_i <= 1'b1;
    cyc(3);
    rd(3'h0, v);
    chk8(v, 8'h00);
    rd(3'h5, v);
    chk8(v, 8'h00);
    chk1(flag_a_o, 1'b0);
    $display("reset done");
    conclude();
  end
endmodule : tb_ctm_top
